// File: otp_prom_asserts.sv
// checker on the wires joining programmer and device
// assumes every input belongs to the single i_clk domain
module otp_prom_asserts (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       mode_select,
  input wire logic       reset_pin_n,
  input wire logic [7:0] port_zero_bits,
  input wire logic [7:0] port_three_bits,
  input wire logic [7:0] prg_data_out,
  input wire logic       prg_data_oe,
  input wire logic       dev_data_oe,
  input wire logic       chip_enable_n,
  input wire logic       out_enable_n,
  input wire logic       write_strobe_n,
  input wire logic [5:0] setting_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] low_cnt_q; // strobe low cycles so far
  logic [31:0] low_cnt_d; // next count
  logic        prom_mode; // pins decode to programming mode
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  assign prom_mode = mode_select && !reset_pin_n && (setting_pins == 6'h12);
  // width counter; a pulse cannot exceed 12500 cycles
  always_comb
  begin
    low_cnt_d = write_strobe_n ? 32'h0 : low_cnt_q + 32'h1;
  end
  // registers only
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      low_cnt_q <= 32'h0;
    else
      low_cnt_q <= low_cnt_d;
  end
  chk_drive_in_read: assert property (dev_data_oe |->
    prom_mode && !chip_enable_n && !out_enable_n && write_strobe_n)
    else $error("device drove data outside a read");
  chk_read_answered: assert property (prom_mode && !chip_enable_n &&
    !out_enable_n && write_strobe_n |-> dev_data_oe)
    else $error("device left a read unanswered");
  chk_run_quiet: assert property (!mode_select |-> !dev_data_oe)
    else $error("data bus driven in run mode");
  chk_no_bus_fight: assert property (!(dev_data_oe && prg_data_oe))
    else $error("both ends drive the data bus");
  chk_pulse_width: assert property ($rose(write_strobe_n) |->
    low_cnt_q == otp_prom_pkg::WRITE_PULSE_CYC)
    else $error("write pulse width wrong");
  chk_pulse_bound: assert property (low_cnt_q <= otp_prom_pkg::WRITE_PULSE_CYC)
    else $error("write pulse too long");
  chk_hold_steady: assert property (!write_strobe_n ##1 !write_strobe_n |->
    $stable(prg_data_out) && $stable(port_zero_bits) && $stable(port_three_bits))
    else $error("address or data moved during a pulse");
  chk_pulse_setup: assert property ($fell(write_strobe_n) |->
    $past(prg_data_oe) && !chip_enable_n && out_enable_n)
    else $error("pulse without data set up");
  chk_entry_straps: assert property (!chip_enable_n |-> prom_mode)
    else $error("access outside programming mode");
  chk_addr_range: assert property (!chip_enable_n |->
    {port_zero_bits, port_three_bits} <= otp_prom_pkg::PROM_LAST)
    else $error("address beyond the array");
  cov_pulse: cover property ($rose(write_strobe_n));
  cov_read: cover property (dev_data_oe);
  cov_verify: cover property ($fell(out_enable_n));
endmodule : otp_prom_asserts

// File: otp_prom_device.sv
// device end: PROM array, mode selection, run-mode fetch and PROM-mode port
// assumes programmer pins are synchronous to i_clk
//
// Summary of operation
// [R1] run mode only while mode select held low; device also runs with it high unless reset low and straps match
// [R2] array at 0x1000-0xFFFF run, 0x0000-0xEFFF programming
// [R3] single clock after reset until enable set
// [R4] address high on port zero, low on three
// [R5] port four is the two-way data bus
// [R6] chip, output enable, write strobe on port one
// [R7] programming mode needs reset low and straps
// [R8] one 0.1 ms low write pulse, then verify
// [R9] retry failed verify, at most 25 pulses
// [R10] final pass verifies every programmed address
// [R11] unused locations hold 0xFF
// [R12] no signature read sequence is ever used
// [R13] image moved down by 0x1000 before writing
// [R14] start 0x0000, 0x3000 or 0x7000, end 0xEFFF
// [R15] clock from resonator or external oscillator input
// [R16] data driven only in a read window
module otp_prom_device (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  otp_prom_if.device       pins,
  input  wire logic [15:0] i_fetch_addr,        // run-mode fetch address
  input  wire logic        i_low_freq_osc_set,  // software sets the enable bit
  output logic      [7:0]  o_fetch_data,        // run-mode fetch data
  output logic             o_fetch_hit,         // fetch address inside PROM
  output logic             o_prom_mode,         // device is in PROM mode
  output logic             o_low_freq_osc_on,   // dual clock running
  output logic      [7:0]  o_system_control_two // shadow of control byte
);

  logic [7:0]  mem [0:otp_prom_pkg::PROM_BYTES-1];  // one-time cells
  logic        prom_mode;                            // decoded mode
  logic [15:0] prom_idx;                             // PROM-mode index
  logic        read_en;                              // data bus read window
  logic        strobe_q;                             // last write strobe
  logic        strobe_d;
  logic        osc_on_q;
  logic        osc_on_d;
  logic [7:0]  rd_q;
  logic [7:0]  rd_d;
  logic [7:0]  fetch_q;
  logic [7:0]  fetch_d;
  logic [15:0] run_idx;

  // mode select: pin high plus straps and reset low means PROM mode
  always_comb
  begin
    prom_mode = pins.mode_select                      // [R1]
              && !pins.reset_pin_n
              && pins.setting_pins == 6'b010010;
  end

  // address from ports zero and three
  assign prom_idx = {pins.port_zero_bits, pins.port_three_bits}; // [R4]

  // output window: chip and output enable low, strobe high
  assign read_en = prom_mode && !pins.chip_enable_n
                && !pins.out_enable_n && pins.write_strobe_n;     // [R6] [R16]

  // run-mode address shifted down by the base
  assign run_idx = i_fetch_addr - otp_prom_pkg::RUN_BASE;         // [R2]

  // next values of the bus, fetch and clock state
  always_comb
  begin
    strobe_d = pins.write_strobe_n;
    rd_d     = otp_prom_pkg::ERASED_BYTE;
    if (prom_idx <= otp_prom_pkg::PROM_LAST)                      // [R2]
    begin
      rd_d = mem[prom_idx];
    end
    fetch_d = otp_prom_pkg::ERASED_BYTE;
    if (!prom_mode && i_fetch_addr >= otp_prom_pkg::RUN_BASE)     // [R2]
    begin
      fetch_d = mem[run_idx];
    end
    // single clock after reset until software sets the bit
    osc_on_d = osc_on_q | (i_low_freq_osc_set & !prom_mode);      // [R3]
  end

  // flops
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strobe_q <= 1'b1;
      osc_on_q <= 1'b0;                                            // [R3]
      rd_q     <= otp_prom_pkg::ERASED_BYTE;
      fetch_q  <= otp_prom_pkg::ERASED_BYTE;
    end
    else
    begin
      strobe_q <= strobe_d;
      osc_on_q <= osc_on_d;
      rd_q     <= rd_d;
      fetch_q  <= fetch_d;
    end
  end

  // cell write on falling strobe edge with chip enabled;
  // one-time cells can only clear bits, never set them back
  always_ff @(posedge i_clk)
  begin
    if (prom_mode && strobe_q && !pins.write_strobe_n
        && !pins.chip_enable_n && pins.out_enable_n
        && prom_idx <= otp_prom_pkg::PROM_LAST)
    begin
      mem[prom_idx] <= mem[prom_idx] & pins.prom_data_bus;        // [R5]
    end
  end

  // data bus: device drives only in the read window
  assign pins.dev_data_out = rd_q;                                 // [R5]
  assign pins.dev_data_oe  = read_en;                              // [R16]

  assign o_fetch_data         = fetch_q;
  assign o_fetch_hit          = !prom_mode && i_fetch_addr >= otp_prom_pkg::RUN_BASE;
  assign o_prom_mode          = prom_mode;
  assign o_low_freq_osc_on    = osc_on_q;
  assign o_system_control_two = {osc_on_q, 7'h00};

endmodule : otp_prom_device

// File: otp_prom_if.sv
// interface joining the device port pins and the programmer
// assumes both ends share i_clk; the bidirectional data bus is resolved here
interface otp_prom_if;
  logic       mode_select;        // test/program-voltage pin, low = run mode
  logic       reset_pin_n;        // device reset pin, held low in PROM mode
  logic [7:0] port_zero_bits;     // address high byte
  logic [7:0] port_three_bits;    // address low byte
  logic [7:0] dev_data_out;       // device drive of data bus
  logic       dev_data_oe;        // device drives data bus
  logic [7:0] prg_data_out;       // programmer drive of data bus
  logic       prg_data_oe;        // programmer drives data bus
  logic       chip_enable_n;      // port 1 bit 3
  logic       out_enable_n;       // port 1 bit 4
  logic       write_strobe_n;     // port 1 bit 5
  logic [5:0] setting_pins;       // p1[2:0], p2[2:0] straps
  logic       osc_input;          // clock presence on oscillator input
  logic [7:0] prom_data_bus;      // resolved data bus level

  // wired bus: pull-up level when nobody drives
  assign prom_data_bus = dev_data_oe ? dev_data_out :
                         prg_data_oe ? prg_data_out : 8'hFF;

  modport device (
    input  mode_select, reset_pin_n, port_zero_bits, port_three_bits,
    input  prg_data_out, prg_data_oe, chip_enable_n, out_enable_n, write_strobe_n,
    input  setting_pins, osc_input, prom_data_bus,
    output dev_data_out, dev_data_oe
  );

  modport programmer (
    output mode_select, reset_pin_n, port_zero_bits, port_three_bits,
    output prg_data_out, prg_data_oe, chip_enable_n, out_enable_n, write_strobe_n,
    output setting_pins, osc_input,
    input  dev_data_out, dev_data_oe, prom_data_bus
  );
endinterface : otp_prom_if

// File: otp_prom_mode_port_tb.sv
// bench: a joined programmer/device pair, and a lone device on a bench driver
// assumes package, interface, both ends and checker are compiled first
module otp_prom_mode_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk;      // 125 MHz
  logic        i_reset_n;  // shared reset
  logic        start;      // session start
  logic [15:0] img_addr;   // image address asked for
  logic [15:0] fetch_addr; // fetch address, both devices
  logic        osc_set;    // low-freq enable request, both devices
  logic [7:0]  fetch_data; // lone device outputs
  logic        fetch_hit;
  logic        prom_mode;
  logic        osc_on;
  logic [7:0]  sys_ctl;
  logic        busy;
  otp_prom_pkg::image_size_t size; // image capacity under test
  logic [7:0]  rd;         // byte read back
  int          fail_count;
  int          comparisons;
  int          cycles;     // watchdog count
  int          n;
  otp_prom_if bus_if ();
  otp_prom_if drv_if ();
  otp_prom_programmer otp_prom_programmer_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .pins(bus_if), .i_start(start), .i_size(size),
    .i_img_data(img_addr[7:0] ^ 8'hA5), .o_img_addr(img_addr), .o_busy(busy),
    .o_done(), .o_fail());
  otp_prom_device otp_prom_device_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .pins(bus_if), .i_fetch_addr(fetch_addr), .i_low_freq_osc_set(osc_set),
    .o_fetch_data(), .o_fetch_hit(), .o_prom_mode(), .o_low_freq_osc_on(),
    .o_system_control_two());
  otp_prom_device otp_prom_device_inst_alone (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .pins(drv_if), .i_fetch_addr(fetch_addr), .i_low_freq_osc_set(osc_set),
    .o_fetch_data(fetch_data), .o_fetch_hit(fetch_hit), .o_prom_mode(prom_mode),
    .o_low_freq_osc_on(osc_on), .o_system_control_two(sys_ctl));
  otp_prom_asserts otp_prom_asserts_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .mode_select(bus_if.mode_select), .reset_pin_n(bus_if.reset_pin_n),
    .port_zero_bits(bus_if.port_zero_bits), .port_three_bits(bus_if.port_three_bits),
    .prg_data_out(bus_if.prg_data_out), .prg_data_oe(bus_if.prg_data_oe),
    .dev_data_oe(bus_if.dev_data_oe), .chip_enable_n(bus_if.chip_enable_n),
    .out_enable_n(bus_if.out_enable_n), .write_strobe_n(bus_if.write_strobe_n),
    .setting_pins(bus_if.setting_pins));
  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // lone device: switch pins between run and programming mode
  task automatic drv_mode(input logic prom);
    @(posedge i_clk);
    drv_if.mode_select <= prom;
    drv_if.reset_pin_n <= ~prom;
    @(posedge i_clk);
  endtask : drv_mode
  // read cycle; answer comes one cycle after the address
  task automatic drv_read(input logic [15:0] a, input logic oe_n, output logic [7:0] d);
    @(posedge i_clk);
    {drv_if.port_zero_bits, drv_if.port_three_bits} <= a;
    drv_if.chip_enable_n <= 1'b0;
    drv_if.out_enable_n <= oe_n;
    repeat (2) @(posedge i_clk);
    #1 d = drv_if.prom_data_bus;
    @(posedge i_clk);
    drv_if.chip_enable_n <= 1'b1;
    drv_if.out_enable_n <= 1'b1;
  endtask : drv_read
  // write cycle: one setup cycle, then one full-width pulse
  task automatic drv_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {drv_if.port_zero_bits, drv_if.port_three_bits} <= a;
    drv_if.prg_data_out <= d;
    drv_if.prg_data_oe <= 1'b1;
    drv_if.chip_enable_n <= 1'b0;
    @(posedge i_clk);
    drv_if.write_strobe_n <= 1'b0;
    repeat (otp_prom_pkg::WRITE_PULSE_CYC) @(posedge i_clk);
    drv_if.write_strobe_n <= 1'b1;
    @(posedge i_clk);
    drv_if.prg_data_oe <= 1'b0;
    drv_if.chip_enable_n <= 1'b1;
  endtask : drv_write
  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;
  // watchdog; the whole run needs about 25100 cycles
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    {i_reset_n, start, osc_set, cycles, fail_count, comparisons} = '0;
    fetch_addr = 16'h0000;
    size = otp_prom_pkg::IMG_32K;
    {drv_if.mode_select, drv_if.port_zero_bits, drv_if.port_three_bits} = '0;
    {drv_if.prg_data_out, drv_if.prg_data_oe} = '0;
    {drv_if.reset_pin_n, drv_if.chip_enable_n, drv_if.out_enable_n} = 3'h7;
    drv_if.write_strobe_n = 1'b1;
    drv_if.setting_pins = 6'h12;
    drv_if.osc_input = 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    #1 check(busy, 1'b1);
    n = 0;
    while (bus_if.write_strobe_n !== 1'b0 && n < 100)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    check({bus_if.port_zero_bits, bus_if.port_three_bits}, 16'h7000);
    check(img_addr, 16'h8000);
    check(bus_if.prom_data_bus, 8'hA5);
    n = 0;
    while (bus_if.write_strobe_n === 1'b0 && n < 13000)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    check(16'(n), 16'(otp_prom_pkg::WRITE_PULSE_CYC));
    n = 0;
    while (bus_if.out_enable_n !== 1'b0 && n < 20)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    check(bus_if.dev_data_oe, 1'b1);
    // abort the session while it recovers from its first pulse
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    #1 check({busy, bus_if.chip_enable_n}, 16'h1);
    check({prom_mode, osc_on, sys_ctl}, 16'h0);
    // larger image starts lower; abort once its first address is out
    @(posedge i_clk);
    size  <= otp_prom_pkg::IMG_48K;
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    #1 check({bus_if.port_zero_bits, bus_if.port_three_bits}, 16'h3000);
    check(img_addr, 16'h4000);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    size      <= otp_prom_pkg::IMG_60K;
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    #1 check({bus_if.port_zero_bits, bus_if.port_three_bits}, 16'h0000);
    check(img_addr, 16'h1000);
    // full image session keeps running beside the lone device tests
    @(posedge i_clk);
    osc_set <= 1'b1;
    @(posedge i_clk);
    osc_set <= 1'b0;
    @(posedge i_clk);
    #1 check({osc_on, sys_ctl}, 16'h180);
    drv_mode(1'b1);
    check(prom_mode, 1'b1);
    drv_write(16'h0123, 8'h00);
    drv_read(16'h0123, 1'b0, rd);
    check(rd, 8'h00);
    drv_read(16'hF000, 1'b0, rd);
    check(rd, 8'hFF);
    drv_read(16'h0123, 1'b1, rd);
    check(rd, 8'hFF);
    drv_mode(1'b0);
    fetch_addr <= 16'h1123;
    repeat (2) @(posedge i_clk);
    #1 check({fetch_hit, fetch_data}, 16'h100);
    @(posedge i_clk);
    fetch_addr <= 16'h0FFF;
    repeat (2) @(posedge i_clk);
    #1 check({fetch_hit, fetch_data}, 16'h0FF);
    conclude();
  end
endmodule : otp_prom_mode_port_tb

// File: otp_prom_pkg.sv
// package for the one-time PROM parallel programming port
// assumes a single 125 MHz clock shared by both ends of the port
package otp_prom_pkg;

  // clock rate and timing
  localparam int unsigned CLK_PERIOD_PS    = 8000;          // 125 MHz clock period
  localparam int unsigned WRITE_PULSE_NS   = 100000;        // 0.1 ms write pulse
  localparam int unsigned WRITE_PULSE_CYC  = (WRITE_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned MAX_WRITE_PULSES = 25;            // pulses per address
  localparam int unsigned READ_SETTLE_CYC  = 4;             // bus turnaround wait

  // memory map
  localparam int unsigned PROM_BYTES       = 61440;         // 60K bytes
  localparam logic [15:0] RUN_BASE         = 16'h1000;      // base in run mode
  localparam logic [15:0] RUN_LAST         = 16'hFFFF;      // last in run mode
  localparam logic [15:0] PROM_FIRST       = 16'h0000;      // first in PROM mode
  localparam logic [15:0] PROM_LAST        = 16'hEFFF;      // last in PROM mode
  localparam logic [15:0] START_48K        = 16'h3000;      // start for 48KB image
  localparam logic [15:0] START_32K        = 16'h7000;      // start for 32KB image
  localparam logic [7:0]  BLANK_BYTE       = 8'hFF;         // unused location value
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;         // value read outside the array, and reset value of read and fetch registers

  // image size selection for the programmer
  typedef enum logic [1:0] {IMG_60K, IMG_48K, IMG_32K} image_size_t;

endpackage : otp_prom_pkg

// File: otp_prom_programmer.sv
// programmer end: relocates, writes with timed pulses, retries and verifies
// assumes an image source that answers i_img_data for o_img_addr combinationally
module otp_prom_programmer (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  otp_prom_if.programmer                 pins,
  input  wire logic                      i_start,     // begin a session
  input  wire otp_prom_pkg::image_size_t i_size,      // image capacity
  input  wire logic [7:0]                i_img_data,  // image byte at run address
  output logic      [15:0]               o_img_addr,  // run-mode image address
  output logic                           o_busy,
  output logic                           o_done,      // finished, all verified
  output logic                           o_fail       // retries or final verify failed
);

  typedef enum {IDLE, SETUP, PULSE, RECOVER, VERIFY, NEXT, FINAL, FRD, FIN} state_t;

  state_t      st_q, st_d;
  logic [15:0] addr_q, addr_d;          // PROM-mode address
  logic [15:0] start_a;
  logic [19:0] cnt_q, cnt_d;            // timing counter
  logic [4:0]  tries_q, tries_d;        // pulses used at this address
  logic        done_q, done_d;
  logic        fail_q, fail_d;
  logic        we_n, oe_n, drive;

  // start address by image size
  always_comb
  begin
    unique case (i_size)
      otp_prom_pkg::IMG_48K: start_a = otp_prom_pkg::START_48K;   // [R14]
      otp_prom_pkg::IMG_32K: start_a = otp_prom_pkg::START_32K;
      default:               start_a = otp_prom_pkg::PROM_FIRST;
    endcase
  end

  // image is read at PROM address plus base
  assign o_img_addr = addr_q + otp_prom_pkg::RUN_BASE;             // [R13]

  // sequencer next state
  always_comb
  begin
    st_d = st_q; addr_d = addr_q; cnt_d = cnt_q; tries_d = tries_q;
    done_d = done_q; fail_d = fail_q;
    unique case (st_q)
      IDLE: if (i_start)
      begin
        addr_d = start_a; tries_d = 5'd0; done_d = 1'b0; fail_d = 1'b0;
        cnt_d = 20'd0; st_d = SETUP;
      end
      SETUP:
      begin
        cnt_d = 20'(otp_prom_pkg::WRITE_PULSE_CYC - 1); st_d = PULSE;
      end
      PULSE:                                                      // [R8]
        if (cnt_q == 20'd0)
        begin
          tries_d = tries_q + 5'd1;
          cnt_d = 20'(otp_prom_pkg::READ_SETTLE_CYC); st_d = RECOVER;
        end
        else cnt_d = cnt_q - 20'd1;
      RECOVER:
        if (cnt_q == 20'd0) st_d = VERIFY; else cnt_d = cnt_q - 20'd1;
      VERIFY:                                                     // [R9]
        if (pins.prom_data_bus == i_img_data) st_d = NEXT;
        else if (tries_q == 5'(otp_prom_pkg::MAX_WRITE_PULSES))
        begin
          fail_d = 1'b1; st_d = FIN;
        end
        else st_d = SETUP;
      NEXT:                                                       // [R14]
        if (addr_q == otp_prom_pkg::PROM_LAST)
        begin
          addr_d = start_a; cnt_d = 20'(otp_prom_pkg::READ_SETTLE_CYC); st_d = FINAL;
        end
        else
        begin
          addr_d = addr_q + 16'd1; tries_d = 5'd0; st_d = SETUP;
        end
      FINAL:
        if (cnt_q == 20'd0) st_d = FRD; else cnt_d = cnt_q - 20'd1;
      FRD:                                                        // [R10]
        if (pins.prom_data_bus != i_img_data)
        begin
          fail_d = 1'b1; st_d = FIN;
        end
        else if (addr_q == otp_prom_pkg::PROM_LAST) st_d = FIN;
        else
        begin
          addr_d = addr_q + 16'd1; cnt_d = 20'(otp_prom_pkg::READ_SETTLE_CYC); st_d = FINAL;
        end
      FIN:
      begin
        done_d = !fail_q; st_d = IDLE;
      end
    endcase
  end

  // state flops
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_q <= IDLE; addr_q <= 16'h0000; cnt_q <= 20'h00000; tries_q <= 5'h00;
      done_q <= 1'b0; fail_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; addr_q <= addr_d; cnt_q <= cnt_d; tries_q <= tries_d;
      done_q <= done_d; fail_q <= fail_d;
    end
  end

  // strobe decode: image bytes outside the program area are already 0xFF
  assign we_n  = !(st_q == PULSE);                                // [R8]
  assign drive = st_q == SETUP || st_q == PULSE;                  // [R5] [R11]
  assign oe_n  = !(st_q == RECOVER || st_q == VERIFY || st_q == FINAL || st_q == FRD);

  assign pins.mode_select     = 1'b1;                             // [R1]
  assign pins.reset_pin_n     = 1'b0;                             // [R7]
  assign pins.setting_pins    = 6'b010010;                        // [R7]
  assign pins.osc_input       = 1'b1;                             // [R15]
  assign pins.port_zero_bits  = addr_q[15:8];                     // [R4] [R12]
  assign pins.port_three_bits = addr_q[7:0];
  assign pins.prg_data_out    = i_img_data;
  assign pins.prg_data_oe     = drive;
  assign pins.chip_enable_n   = (st_q == IDLE);                   // [R6]
  assign pins.out_enable_n    = oe_n;
  assign pins.write_strobe_n  = we_n;

  assign o_busy = st_q != IDLE;
  assign o_done = done_q;
  assign o_fail = fail_q;

endmodule : otp_prom_programmer
